// *** lcd_seg_defines.svh ***
`ifndef LCD_SEG_DEFINES_SVH
`define LCD_SEG_DEFINES_SVH

// serial word layout
`define LCD_WORD_BITS        8
`define LCD_OP_MSB           7
`define LCD_OP_LSB           5
`define LCD_ADDR_FIELD_MSB   4
`define LCD_NIB_FIELD_MSB    3

// command opcodes (top three bits of a command word)
`define LCD_OP_ADDR_SET      3'h0
`define LCD_OP_ALL_ON        3'h1
`define LCD_OP_ALL_OFF       3'h2
`define LCD_OP_NORMAL        3'h3
`define LCD_OP_NIB_WRITE     3'h4
`define LCD_OP_RESET         3'h6

// display memory geometry
`define LCD_MEM_DEPTH        32
`define LCD_MEM_WIDTH        4
`define LCD_ADDR_W           5

// address steps
`define LCD_ADDR_STEP_BYTE   5'h02
`define LCD_ADDR_STEP_NIB    5'h01
`define LCD_ADDR_RESET       5'h00

// drive level codes
`define LCD_LVL_VDD          2'h0
`define LCD_LVL_V1           2'h1
`define LCD_LVL_V2           2'h2
`define LCD_LVL_V3           2'h3

// timing: oscillator ticks per common phase
`define LCD_TICKS_PER_PHASE  36

`endif

// *** lcd_seg_pkg.sv ***
package lcd_seg_pkg;

	// display output mode
	typedef enum logic [1:0] {
		DISP_NORMAL  = 2'b00,
		DISP_ALL_ON  = 2'b01,
		DISP_ALL_OFF = 2'b10
	} disp_mode_e;

	// 2-bit drive level code
	typedef logic [1:0] level_t;

endpackage : lcd_seg_pkg

// *** lcd_seg_mem.sv ***
`include "lcd_seg_defines.svh"

// 32x4 display memory, two write ports, one registered bit-slice read
module lcd_seg_mem #(
	parameter int DEPTH = `LCD_MEM_DEPTH,
	parameter int WIDTH = `LCD_MEM_WIDTH
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     wr_en_a,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_a,
	input  wire logic [WIDTH-1:0]         wr_data_a,
	input  wire logic                     wr_en_b,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_b,
	input  wire logic [WIDTH-1:0]         wr_data_b,
	input  wire logic [$clog2(WIDTH)-1:0] rd_bit_sel,
	output logic      [DEPTH-1:0]         rd_slice
);

	logic [WIDTH-1:0] mem      [DEPTH];  // storage
	logic [WIDTH-1:0] next_mem [DEPTH];  // next storage
	logic [DEPTH-1:0] next_rd_slice;     // next read slice

	// elaboration check: slice select needs at least two bits and words
	if (DEPTH < 2 || WIDTH < 2) begin : g_bad_size
		$error("lcd_seg_mem: DEPTH and WIDTH must be at least 2");
	end

	// write ports and slice read, port b wins on same address
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
			next_rd_slice[i] = mem[i][rd_bit_sel];
		end
		if (wr_en_a) begin
			next_mem[wr_addr_a] = wr_data_a;
		end
		if (wr_en_b) begin
			next_mem[wr_addr_b] = wr_data_b;
		end
	end

	// register storage and read data
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			rd_slice <= '0;
		end else begin
			mem      <= next_mem;
			rd_slice <= next_rd_slice;
		end
	end

endmodule : lcd_seg_mem

// *** lcd_segment_serial_driver.sv ***
`include "lcd_seg_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] eight-bit shift register with three-bit counter
// [RULE_02] chip select falling clears counter, opens input
// [RULE_03] oscillator start also clears the counter; an accepted shift edge in the same cycle increments it instead
// [RULE_04] sample on shift rise, msb first
// [RULE_05] counter returns to zero after eight edges
// [RULE_06] full word goes to memory or decoder
// [RULE_07] select sampled at eighth edge, high=command
// [RULE_08] data bit one lights, zero darkens segment
// [RULE_09] command words decoded to control device
// [RULE_10] memory is thirty-two four-bit locations
// [RULE_11] byte writes two nibbles, address plus two
// [RULE_12] opcode 100 writes one nibble, plus one
// [RULE_13] incremented address kept until set again
// [RULE_14] five-bit presettable address counter
// [RULE_15] address wraps from thirty-one to zero
// [RULE_16] thirty-two bits read out per phase
// [RULE_17] common counter makes phase and polarity
// [RULE_18] rc oscillator or external clock input
// [RULE_19] four-level drive for all outputs
// [RULE_20] opcode 000 loads address from low bits
// [RULE_21] 001 all on, 010 all off
// [RULE_22] 011 returns to normal display
// [RULE_23] 110 resets, display turned off
// [RULE_24] unknown opcodes are ignored
// [RULE_25] segment level from phase, polarity, bit
module lcd_segment_serial_driver
	import lcd_seg_pkg::*;
#(
	parameter int TICKS_PER_PHASE = `LCD_TICKS_PER_PHASE
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        shift_clock_in,
	input  wire logic        serial_data_in,
	input  wire logic        chip_sel_n,
	input  wire logic        cmd_sel,
	input  wire logic        rc_node_in,
	output logic             rc_node_out,
	output logic [7:0]       backplane_drive,
	output logic [63:0]      frontplane_drive
);

	localparam int DIV_W = $clog2(TICKS_PER_PHASE + 1);

	if (TICKS_PER_PHASE < 1) begin : g_bad_ticks
		$error("TICKS_PER_PHASE must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// serial input

	logic        sck_prev;        // last shift clock level
	logic        cs_prev_n;       // last chip select level
	logic        rc_prev;         // last oscillator level
	logic        osc_seen;        // oscillator has ticked
	logic        accept;          // input opened by chip select
	logic [7:0]  shreg;           // serial shift register
	logic [2:0]  bit_cnt;         // edges in current word
	logic        word_done;       // one-cycle word complete pulse
	logic        word_is_cmd;     // completed word was a command
	logic [7:0]  word;            // completed word
	logic        next_accept;
	logic        next_osc_seen;
	logic [7:0]  next_shreg;
	logic [2:0]  next_bit_cnt;
	logic        next_word_done;
	logic        next_word_is_cmd;
	logic [7:0]  next_word;
	logic        sck_rise;        // shift clock rising edge
	logic        cs_fall;         // chip select falling edge
	logic        rc_tick;         // oscillator rising edge
	logic        osc_start;       // first oscillator edge

	assign sck_rise  = shift_clock_in & ~sck_prev;
	assign cs_fall   = ~chip_sel_n & cs_prev_n;
	assign rc_tick   = rc_node_in & ~rc_prev;
	assign osc_start = rc_tick & ~osc_seen;

	// shift, count and word completion
	always_comb begin
		next_accept      = accept;
		next_osc_seen    = osc_seen | rc_tick;
		next_shreg       = shreg;
		next_bit_cnt     = (chip_sel_n && osc_start) ? 3'h0 : bit_cnt; // [RULE_03]
		next_word_done   = 1'b0;
		next_word_is_cmd = word_is_cmd;
		next_word        = word;
		if (chip_sel_n) begin
			// deselected: input closed
			next_accept = 1'b0;
		end else if (cs_fall) begin
			// open input, restart word
			next_accept  = 1'b1; // [RULE_02]
			next_bit_cnt = 3'h0; // [RULE_02]
		end else if (accept && sck_rise) begin
			// msb arrives first, so shift left
			next_shreg   = {shreg[6:0], serial_data_in}; // [RULE_01] [RULE_04]
			next_bit_cnt = bit_cnt + 3'h1; // [RULE_01] [RULE_05]
			if (bit_cnt == 3'h7) begin
				// eighth edge: hand word on, sample select
				next_word_done   = 1'b1; // [RULE_06]
				next_word        = {shreg[6:0], serial_data_in}; // [RULE_06]
				next_word_is_cmd = cmd_sel; // [RULE_07]
			end
		end else if (osc_start) begin
			// oscillator start restarts the word
			next_bit_cnt = 3'h0; // [RULE_03]
		end
	end

	// serial registers
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_prev    <= 1'b0;
			cs_prev_n   <= 1'b1;
			rc_prev     <= 1'b0;
			osc_seen    <= 1'b0;
			accept      <= 1'b0;
			shreg       <= 8'h00;
			bit_cnt     <= 3'h0;
			word_done   <= 1'b0;
			word_is_cmd <= 1'b0;
			word        <= 8'h00;
		end else begin
			sck_prev    <= shift_clock_in;
			cs_prev_n   <= chip_sel_n;
			rc_prev     <= rc_node_in;
			osc_seen    <= next_osc_seen;
			accept      <= next_accept;
			shreg       <= next_shreg;
			bit_cnt     <= next_bit_cnt;
			word_done   <= next_word_done;
			word_is_cmd <= next_word_is_cmd;
			word        <= next_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command decoder and address counter

	logic [4:0]  addr;             // write address counter
	disp_mode_e  disp_mode;        // display mode
	logic [4:0]  next_addr;
	disp_mode_e  next_disp_mode;
	logic        wr_en_a;          // upper nibble / single nibble port
	logic        wr_en_b;          // lower nibble port
	logic [4:0]  wr_addr_b;        // following address
	logic [3:0]  wr_data_a;
	logic [2:0]  opcode;           // top bits of word

	assign opcode    = word[`LCD_OP_MSB:`LCD_OP_LSB];
	assign wr_addr_b = addr + `LCD_ADDR_STEP_NIB; // [RULE_15]

	// data writes and command execution
	always_comb begin
		next_addr      = addr;
		next_disp_mode = disp_mode;
		wr_en_a        = 1'b0;
		wr_en_b        = 1'b0;
		wr_data_a      = word[7:4];
		if (word_done && !word_is_cmd) begin
			// data byte: upper nibble here, lower next
			wr_en_a   = 1'b1; // [RULE_11] [RULE_08]
			wr_en_b   = 1'b1; // [RULE_11]
			next_addr = addr + `LCD_ADDR_STEP_BYTE; // [RULE_11] [RULE_13] [RULE_15]
		end else if (word_done) begin
			// command word
			case (opcode) // [RULE_09]
				`LCD_OP_ADDR_SET: begin
					next_addr = word[`LCD_ADDR_FIELD_MSB:0]; // [RULE_20] [RULE_14]
				end
				`LCD_OP_ALL_ON: begin
					next_disp_mode = DISP_ALL_ON; // [RULE_21]
				end
				`LCD_OP_ALL_OFF: begin
					next_disp_mode = DISP_ALL_OFF; // [RULE_21]
				end
				`LCD_OP_NORMAL: begin
					next_disp_mode = DISP_NORMAL; // [RULE_22]
				end
				`LCD_OP_NIB_WRITE: begin
					wr_en_a   = 1'b1; // [RULE_12]
					wr_data_a = word[`LCD_NIB_FIELD_MSB:0]; // [RULE_12]
					next_addr = addr + `LCD_ADDR_STEP_NIB; // [RULE_12] [RULE_13] [RULE_15]
				end
				`LCD_OP_RESET: begin
					next_disp_mode = DISP_ALL_OFF; // [RULE_23]
					next_addr      = `LCD_ADDR_RESET; // [RULE_23]
				end
				default: begin
					// undefined opcode: no effect
					next_addr = addr; // [RULE_24]
				end
			endcase
		end
	end

	// control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			addr      <= `LCD_ADDR_RESET;
			disp_mode <= DISP_ALL_OFF;
		end else begin
			addr      <= next_addr;
			disp_mode <= next_disp_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display memory

	logic [31:0] seg_slice;        // bits for current phase
	logic [1:0]  phase;            // current common phase

	lcd_seg_mem #(
		.DEPTH (`LCD_MEM_DEPTH),
		.WIDTH (`LCD_MEM_WIDTH)
	) u_mem (
		.clk        (clk),
		.rst        (rst),
		.wr_en_a    (wr_en_a),
		.wr_addr_a  (addr),
		.wr_data_a  (wr_data_a),
		.wr_en_b    (wr_en_b),
		.wr_addr_b  (wr_addr_b),
		.wr_data_b  (word[3:0]),
		.rd_bit_sel (~phase), // [RULE_16] [RULE_10]
		.rd_slice   (seg_slice)
	);

	////////////////////////////////////////////////////////////////////////////
	// timing generator and common counter

	logic [DIV_W-1:0] div_cnt;     // ticks within phase
	logic             pol;         // frame polarity
	logic [1:0]       phase_d;     // phase aligned to slice
	logic             pol_d;       // polarity aligned to slice
	logic [DIV_W-1:0] next_div_cnt;
	logic [1:0]       next_phase;
	logic             next_pol;

	// divide oscillator ticks into phases and frames
	always_comb begin
		next_div_cnt = div_cnt;
		next_phase   = phase;
		next_pol     = pol;
		if (rc_tick) begin
			if (div_cnt == DIV_W'(TICKS_PER_PHASE - 1)) begin
				next_div_cnt = '0;
				next_phase   = phase + 2'h1; // [RULE_17]
				if (phase == 2'h3) begin
					next_pol = ~pol; // [RULE_17]
				end
			end else begin
				next_div_cnt = div_cnt + DIV_W'(1);
			end
		end
	end

	// timing registers, feedback inverter for the rc network
	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt     <= '0;
			phase       <= 2'h0;
			pol         <= 1'b0;
			phase_d     <= 2'h0;
			pol_d       <= 1'b0;
			rc_node_out <= 1'b1;
		end else begin
			div_cnt     <= next_div_cnt;
			phase       <= next_phase;
			pol         <= next_pol;
			phase_d     <= phase;
			pol_d       <= pol;
			rc_node_out <= ~rc_node_in; // [RULE_18]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// segment and common drivers

	logic [7:0]  next_backplane;
	logic [63:0] next_frontplane;
	logic        seg_on;           // effective segment state

	// one-third bias levels per phase and polarity
	always_comb begin
		seg_on = 1'b0;
		for (int c = 0; c < 4; c++) begin
			if (phase_d == 2'(c)) begin
				next_backplane[2*c +: 2] = pol_d ? `LCD_LVL_V3 : `LCD_LVL_VDD; // [RULE_19]
			end else begin
				next_backplane[2*c +: 2] = pol_d ? `LCD_LVL_V1 : `LCD_LVL_V2; // [RULE_19]
			end
		end
		for (int s = 0; s < 32; s++) begin
			case (disp_mode)
				DISP_ALL_ON:  seg_on = 1'b1; // [RULE_21]
				DISP_ALL_OFF: seg_on = 1'b0; // [RULE_21]
				default:      seg_on = seg_slice[s]; // [RULE_08] [RULE_22]
			endcase
			if (seg_on) begin
				next_frontplane[2*s +: 2] = pol_d ? `LCD_LVL_VDD : `LCD_LVL_V3; // [RULE_25]
			end else begin
				next_frontplane[2*s +: 2] = pol_d ? `LCD_LVL_V2 : `LCD_LVL_V1; // [RULE_25]
			end
		end
	end

	// drive registers
	always_ff @(posedge clk) begin
		if (rst) begin
			backplane_drive  <= '0;
			frontplane_drive <= '0;
		end else begin
			backplane_drive  <= next_backplane;
			frontplane_drive <= next_frontplane;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_CS_CLEAR: assert property (cs_fall |=> bit_cnt == 3'h0) // [RULE_02]
		else $error("bit counter not cleared by chip select");
	AST_OSC_CLEAR: assert property (osc_start && chip_sel_n |=> bit_cnt == 3'h0) // [RULE_03]
		else $error("bit counter not cleared at oscillator start");
	AST_SHIFT_MSB: assert property (accept && !chip_sel_n && !cs_fall && sck_rise
		|=> shreg == {$past(shreg[6:0]), $past(serial_data_in)}) // [RULE_04]
		else $error("serial bit not shifted in msb first");
	AST_WORD_END: assert property (accept && !chip_sel_n && !cs_fall && sck_rise && bit_cnt == 3'h7
		|=> word_done && bit_cnt == 3'h0 && word_is_cmd == $past(cmd_sel)) // [RULE_05]
		else $error("word not completed on eighth edge");
	AST_BYTE_ADDR: assert property (word_done && !word_is_cmd |=> addr == $past(addr) + 5'h02) // [RULE_11]
		else $error("address not advanced by two");
	AST_NIB_ADDR: assert property (word_done && word_is_cmd && opcode == `LCD_OP_NIB_WRITE
		|=> addr == $past(addr) + 5'h01) // [RULE_12]
		else $error("address not advanced by one");
	AST_ADDR_SET: assert property (word_done && word_is_cmd && opcode == `LCD_OP_ADDR_SET
		|=> addr == $past(word[4:0])) // [RULE_20]
		else $error("address set failed");
	AST_ADDR_HOLD: assert property (!word_done |=> $stable(addr)) // [RULE_13]
		else $error("address moved without a write");
	AST_ALL_ON: assert property (word_done && word_is_cmd && opcode == `LCD_OP_ALL_ON
		|=> disp_mode == DISP_ALL_ON ##1 frontplane_drive[1:0] == ($past(pol_d) ? 2'h0 : 2'h3)) // [RULE_21]
		else $error("all-on not applied");
	AST_RESET_CMD: assert property (word_done && word_is_cmd && opcode == `LCD_OP_RESET
		|=> disp_mode == DISP_ALL_OFF && addr == 5'h00) // [RULE_23]
		else $error("reset command not applied");
	AST_BAD_OP: assert property (word_done && word_is_cmd && (opcode == 3'h5 || opcode == 3'h7)
		|=> $stable(addr) && $stable(disp_mode)) // [RULE_24]
		else $error("undefined opcode had an effect");
	AST_PHASE_STEP: assert property (rc_tick && div_cnt == DIV_W'(TICKS_PER_PHASE - 1)
		|=> phase == $past(phase) + 2'h1) // [RULE_17]
		else $error("common phase did not advance");
	AST_SEG_OFF: assert property (!$past(rst) && $past(disp_mode) == DISP_ALL_OFF
		|-> frontplane_drive[1:0] == ($past(pol_d) ? 2'h2 : 2'h1)) // [RULE_25]
		else $error("segment not at off level");

	COV_DATA_WORD: cover property (word_done && !word_is_cmd);
	COV_CMD_WORD: cover property (word_done && word_is_cmd && opcode == `LCD_OP_NIB_WRITE);
	COV_ADDR_WRAP: cover property (addr == 5'h1F ##1 addr == 5'h00);
	COV_POL_FLIP: cover property ($changed(pol));

endmodule : lcd_segment_serial_driver

// *** host_link_model.sv ***
////////////////////////////////////////////////////////////////////////////////
// host side of the serial link, driven on falling clock edges
module host_link_model (
	input  wire logic clk,
	output logic      shift_clock_in,
	output logic      serial_data_in,
	output logic      chip_sel_n,
	output logic      cmd_sel
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected, shift clock parked low
	initial begin
		shift_clock_in = 1'b0;
		serial_data_in = 1'b0;
		chip_sel_n     = 1'b1;
		cmd_sel        = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// select high then low, settle before first bit
	task automatic open_frame();
		@(negedge clk) chip_sel_n = 1'b1;
		@(negedge clk) chip_sel_n = 1'b0;
		repeat (2) @(negedge clk);
	endtask : open_frame

	// deselect, data line goes stale
	task automatic close_frame();
		@(negedge clk) chip_sel_n = 1'b1;
		serial_data_in = ~serial_data_in;
	endtask : close_frame

	// n bits msb first, select level held over each edge
	task automatic send_bits(input logic [7:0] w, input logic is_cmd, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			@(negedge clk) serial_data_in = w[i];
			cmd_sel = is_cmd;
			@(negedge clk) shift_clock_in = 1'b1;
			@(negedge clk) shift_clock_in = 1'b0;
		end
		// hold time over: stale levels on both lines
		@(negedge clk) serial_data_in = ~serial_data_in;
		cmd_sel = ~is_cmd;
	endtask : send_bits
endmodule : host_link_model

// *** lcd_segment_serial_driver_bench.sv ***
////////////////////////////////////////////////////////////////////////////////
// self-checking bench with a behavioural display model
module lcd_segment_serial_driver_bench;
	import lcd_seg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TPP = 2;         // shortened ticks per phase

	logic        clk;
	logic        rst;
	logic        shift_clock_in;
	logic        serial_data_in;
	logic        chip_sel_n;
	logic        cmd_sel;
	logic        rc_node_in;
	logic        rc_node_out;
	logic [7:0]  backplane_drive;
	logic [63:0] frontplane_drive;
	int          num_errors;        // mismatches
	int          checked;           // comparisons
	int          mem_m[32];         // model memory
	int          addr_m;            // model address
	disp_mode_e  mode_m;            // model display mode
	int          ticks;             // oscillator ticks since reset
	logic [7:0]  v;                 // random word

	lcd_segment_serial_driver #(.TICKS_PER_PHASE(TPP)) uut (
		.clk              (clk),
		.rst              (rst),
		.shift_clock_in   (shift_clock_in),
		.serial_data_in   (serial_data_in),
		.chip_sel_n       (chip_sel_n),
		.cmd_sel          (cmd_sel),
		.rc_node_in       (rc_node_in),
		.rc_node_out      (rc_node_out),
		.backplane_drive  (backplane_drive),
		.frontplane_drive (frontplane_drive)
	);

	host_link_model host (
		.clk            (clk),
		.shift_clock_in (shift_clock_in),
		.serial_data_in (serial_data_in),
		.chip_sel_n     (chip_sel_n),
		.cmd_sel        (cmd_sel)
	);

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// expected drive levels from model phase, polarity and memory
	task automatic check_display();
		logic [7:0]  bp;
		logic [63:0] fp;
		int          p;
		int          pol;
		int          b;
		p = (ticks / TPP) % 4;
		pol = (ticks / (4 * TPP)) % 2;
		for (int c = 0; c < 4; c++)
			bp[2*c +: 2] = (c == p) ? (pol ? 2'h3 : 2'h0) : (pol ? 2'h1 : 2'h2);
		for (int s = 0; s < 32; s++) begin
			b = (mode_m == DISP_ALL_ON) ? 1 : (mode_m == DISP_ALL_OFF) ? 0 : (mem_m[s] >> (3 - p)) & 1;
			fp[2*s +: 2] = (b != 0) ? (pol ? 2'h0 : 2'h3) : (pol ? 2'h2 : 2'h1);
		end
		cmp(backplane_drive, bp);
		cmp(frontplane_drive, fp);
	endtask : check_display

	// one oscillator tick, output node follows inverted
	task automatic tick();
		@(negedge clk) rc_node_in = 1'b1;
		ticks++;
		@(negedge clk) cmp(rc_node_out, 1'b0);
		@(negedge clk) rc_node_in = 1'b0;
		repeat (4) @(negedge clk);
	endtask : tick

	// two full frames, every phase of both polarities
	task automatic scan();
		for (int k = 0; k < 8; k++) begin
			repeat (TPP) tick();
			check_display();
		end
	endtask : scan

	// send a word and update the model
	task automatic word(input logic [7:0] w, input logic is_cmd);
		host.send_bits(w, is_cmd, 8);
		if (!is_cmd) begin
			mem_m[addr_m] = w[7:4];
			mem_m[(addr_m + 1) % 32] = w[3:0];
			addr_m = (addr_m + 2) % 32;
		end else case (w[7:5])
			3'h0: addr_m = w[4:0];
			3'h1: mode_m = DISP_ALL_ON;
			3'h2: mode_m = DISP_ALL_OFF;
			3'h3: mode_m = DISP_NORMAL;
			3'h4: begin
				mem_m[addr_m] = w[3:0];
				addr_m = (addr_m + 1) % 32;
			end
			3'h6: begin
				mode_m = DISP_ALL_OFF;
				addr_m = 0;
			end
			default: ;
		endcase
		repeat (6) @(negedge clk);
	endtask : word

	// verdict and end of run
	task automatic stop_test();
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		num_errors = 0;
		checked = 0;
		ticks = 0;
		addr_m = 0;
		mode_m = DISP_ALL_OFF;
		foreach (mem_m[i]) mem_m[i] = 0;
		v = 8'($urandom(32'h411A99A9));
		rst = 1'b1;
		rc_node_in = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		// all-on command while deselected must be ignored
		host.send_bits(8'h20, 1'b1, 8);
		repeat (6) @(negedge clk);
		check_display();
		// partial word left pending, oscillator starts while deselected
		host.open_frame();
		host.send_bits(8'hFF, 1'b0, 3);
		host.close_frame();
		tick();
		host.open_frame();
		word(8'h60, 1'b1);
		word(8'h1E, 1'b1);
		for (int i = 0; i < 2; i++) word(8'($urandom), 1'b0);
		word(8'h80 | (8'($urandom) & 8'h1F), 1'b1);
		scan();
		// undefined opcodes leave everything alone
		word(8'hBF, 1'b1);
		word(8'hFF, 1'b1);
		word(v, 1'b0);
		check_display();
		// all on, all off, back to normal
		for (int k = 1; k < 4; k++) begin
			word({3'(k), 5'($urandom)}, 1'b1);
			check_display();
		end
		// partial word dropped by reselect
		host.send_bits(8'hFF, 1'b0, 3);
		host.close_frame();
		host.open_frame();
		word(8'($urandom), 1'b0);
		check_display();
		// reset command, then refill all of memory
		word(8'hC0, 1'b1);
		check_display();
		for (int i = 0; i < 16; i++) word(8'($urandom), 1'b0);
		word(8'h60, 1'b1);
		scan();
		host.close_frame();
		stop_test();
	end

	// hang guard, far beyond the expected run
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end
endmodule : lcd_segment_serial_driver_bench
